// ==== include/timer_pkg.sv ====
// Constants and types shared by the reloadable timer channel
package timer_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_TIMER = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   // ==========================================================
   // Widths and values
   localparam int CNT_W = 16;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
   localparam int PRE_W = 5;
   localparam logic [4:0] DIV_EIGHT_LAST = 5'h07;
   localparam logic [4:0] DIV_THIRTY_TWO_LAST = 5'h1F;
   // ==========================================================
   // Synchronised pin indices
   localparam int PIN_N = 3;
   localparam int PIN_GATE = 0;
   localparam int PIN_DIR = 1;
   localparam int PIN_SUB = 2;
   // ==========================================================
   // Source selects: clock in timer mode, event in event mode
   localparam logic [1:0] CLK_UNDIV = 2'h0;
   localparam logic [1:0] CLK_DIV8 = 2'h1;
   localparam logic [1:0] CLK_DIV32 = 2'h2;
   localparam logic [1:0] CLK_SUB32 = 2'h3;
   localparam logic [1:0] SRC_PIN = 2'h0;
   localparam logic [1:0] SRC_B_ONE = 2'h1;
   localparam logic [1:0] SRC_X_ZERO = 2'h2;
   localparam logic [1:0] SRC_X_TWO = 2'h3;
   // ==========================================================
   // Register layouts
   typedef enum logic [1:0] {
      MODE_TIMER = 2'b00,
      MODE_EVENT = 2'b01,
      MODE_ONE_SHOT = 2'b10,
      MODE_PWM = 2'b11
   } op_mode_t;
   typedef struct packed {
      logic [1:0] src;
      logic free_run;
      logic opt_b;
      logic opt_a;
      logic pulse_en;
      op_mode_t mode;
   } mode_reg_t;
   typedef struct packed {
      logic up;
      logic start;
   } ctrl_reg_t;
   localparam mode_reg_t MODE_RST = '{2'h0, 1'b0, 1'b0, 1'b0, 1'b0,
                                      MODE_TIMER};
   localparam ctrl_reg_t CTRL_RST = '{1'b0, 1'b0};
endpackage : timer_pkg

// ==== include/timer_links_if.sv ====
// Links between the pin synchroniser, prescaler and timer core
`timescale 1ns/1ps
interface timer_links_if;
   logic [timer_pkg::PIN_N-1:0] lvl;
   logic [timer_pkg::PIN_N-1:0] rise;
   logic [timer_pkg::PIN_N-1:0] fall;
   logic tick_div8;
   logic tick_div32;
   logic tick_sub32;
   modport sync_mp (output lvl, output rise, output fall);
   modport presc_mp (input rise, output tick_div8, output tick_div32,
                     output tick_sub32);
   modport core_mp (input lvl, input rise, input fall, input tick_div8,
                    input tick_div32, input tick_sub32);
endinterface : timer_links_if

// ==== hdl/pin_sync.sv ====
// Two-flop synchroniser and edge detector for the timer pins
`timescale 1ns/1ps
module pin_sync (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [timer_pkg::PIN_N-1:0] pins_i,
   timer_links_if.sync_mp links
);
   typedef struct packed {
      logic [timer_pkg::PIN_N-1:0] s1;
      logic [timer_pkg::PIN_N-1:0] s2;
      logic [timer_pkg::PIN_N-1:0] s3;
   } sync_st_t;
   sync_st_t st_r;
   sync_st_t st_nxt;
   // ==========================================================
   // Sampling chain; edges come from second and third stage
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = pins_i;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign links.lvl = st_r.s2;
   assign links.rise = st_r.s2 & ~st_r.s3;
   assign links.fall = ~st_r.s2 & st_r.s3;
endmodule : pin_sync

// ==== hdl/tick_prescaler.sv ====
// Divided clock enables for the timer count source
`timescale 1ns/1ps
module tick_prescaler (
   input wire logic clk_i,
   input wire logic rst_n_i,
   timer_links_if.presc_mp links
);
   typedef struct packed {
      logic [timer_pkg::PRE_W-1:0] div_cnt;
      logic [timer_pkg::PRE_W-1:0] sub_cnt;
      logic t8;
      logic t32;
      logic ts;
   } pre_st_t;
   pre_st_t st_r;
   pre_st_t st_nxt;
   // ==========================================================
   // Free running dividers
   always_comb begin
      st_nxt = st_r;
      st_nxt.div_cnt = st_r.div_cnt + 5'h01;
      st_nxt.t8 = (st_r.div_cnt[2:0] == timer_pkg::DIV_EIGHT_LAST[2:0]);
      st_nxt.t32 = (st_r.div_cnt == timer_pkg::DIV_THIRTY_TWO_LAST);
      st_nxt.ts = 1'b0;
      if (links.rise[timer_pkg::PIN_SUB]) begin
         st_nxt.sub_cnt = st_r.sub_cnt + 5'h01;
         st_nxt.ts = (st_r.sub_cnt == timer_pkg::DIV_THIRTY_TWO_LAST);
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign links.tick_div8 = st_r.t8;
   assign links.tick_div32 = st_r.t32;
   assign links.tick_sub32 = st_r.ts;
endmodule : tick_prescaler

// ==== hdl/gp_timer.sv ====
// Reloadable 16-bit timer channel: timer and event counter modes
`timescale 1ns/1ps
module gp_timer (
   input wire logic SYS_CLK_I,
   input wire logic RST_B_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic EVENT_GATE_INPUT_PIN_I,
   input wire logic TOGGLE_DIRECTION_PIN_I,
   output logic TOGGLE_DIRECTION_PIN_O,
   output logic TOGGLE_DIRECTION_PIN_OE_O,
   input wire logic SUBCLOCK_I,
   input wire logic B_TIMER_ONE_OVF_I,
   input wire logic X_TIMER_ZERO_OVF_I,
   input wire logic X_TIMER_TWO_OVF_I,
   output logic IRQ_O
);
   typedef struct packed {
      timer_pkg::ctrl_reg_t ctrl;
      timer_pkg::mode_reg_t mode;
      logic [timer_pkg::CNT_W-1:0] reload;
      logic [timer_pkg::CNT_W-1:0] cnt;
      logic out_lvl;
      logic out_oe;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } core_st_t;
   localparam core_st_t CORE_RST = '{timer_pkg::CTRL_RST,
      timer_pkg::MODE_RST, timer_pkg::CNT_ZERO, timer_pkg::CNT_ZERO,
      1'b0, 1'b0, 1'b0, timer_pkg::DATA_ZERO, 1'b0, 1'b0};

   core_st_t st_r;
   core_st_t st_nxt;
   logic [1:0] rst_sync_r;
   logic rst_n;
   logic setup_c;
   logic wr_c;
   logic wr_timer_c;
   logic is_timer_c;
   logic is_event_c;
   logic clk_tick_c;
   logic gate_ok_c;
   logic ev_tick_c;
   logic up_c;
   logic step_c;
   logic wrap_c;

   timer_links_if links ();

   // ==========================================================
   // Reset release
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // ==========================================================
   // Pin synchroniser and count source prescaler
   pin_sync u_sync (
      .clk_i(SYS_CLK_I),
      .rst_n_i(rst_n),
      .pins_i({SUBCLOCK_I, TOGGLE_DIRECTION_PIN_I,
               EVENT_GATE_INPUT_PIN_I}),
      .links(links.sync_mp)
   );
   tick_prescaler u_presc (
      .clk_i(SYS_CLK_I),
      .rst_n_i(rst_n),
      .links(links.presc_mp)
   );

   // ==========================================================
   // Bus decode
   assign setup_c = PSEL_I & ~PENABLE_I;
   assign wr_c = PSEL_I & PENABLE_I & st_r.pready & PWRITE_I;
   assign wr_timer_c = wr_c & (PADDR_I == timer_pkg::ADDR_TIMER);

   // ==========================================================
   // Count source selection
   assign is_timer_c = (st_r.mode.mode == timer_pkg::MODE_TIMER);
   assign is_event_c = (st_r.mode.mode == timer_pkg::MODE_EVENT);

   always_comb begin
      unique case (st_r.mode.src)
         timer_pkg::CLK_UNDIV: clk_tick_c = 1'b1;
         timer_pkg::CLK_DIV8: clk_tick_c = links.tick_div8;
         timer_pkg::CLK_DIV32: clk_tick_c = links.tick_div32;
         timer_pkg::CLK_SUB32: clk_tick_c = links.tick_sub32;
      endcase
   end

   always_comb begin
      unique case (st_r.mode.src)
         timer_pkg::SRC_PIN: begin
            ev_tick_c = st_r.mode.opt_a ? links.rise[timer_pkg::PIN_GATE]
                                        : links.fall[timer_pkg::PIN_GATE];
         end
         timer_pkg::SRC_B_ONE: ev_tick_c = B_TIMER_ONE_OVF_I;
         timer_pkg::SRC_X_ZERO: ev_tick_c = X_TIMER_ZERO_OVF_I;
         timer_pkg::SRC_X_TWO: ev_tick_c = X_TIMER_TWO_OVF_I;
      endcase
   end

   // Gate: opt_a enables it, opt_b picks the active level
   assign gate_ok_c = ~st_r.mode.opt_a |
      (links.lvl[timer_pkg::PIN_GATE] == st_r.mode.opt_b);

   // Direction: opt_b takes it from the direction pin input level
   assign up_c = is_event_c & (st_r.mode.opt_b
      ? links.lvl[timer_pkg::PIN_DIR] : st_r.ctrl.up);

   assign step_c = st_r.ctrl.start & ((is_timer_c & clk_tick_c & gate_ok_c)
      | (is_event_c & ev_tick_c));
   assign wrap_c = step_c & (up_c ? (st_r.cnt == timer_pkg::CNT_MAX)
      : (st_r.cnt == timer_pkg::CNT_ZERO));

   // ==========================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.irq = 1'b0;
      // Counter
      if (step_c) begin
         if (wrap_c) begin
            if (is_event_c && st_r.mode.free_run) begin
               st_nxt.cnt = up_c ? timer_pkg::CNT_ZERO
                                 : timer_pkg::CNT_MAX;
            end else begin
               st_nxt.cnt = st_r.reload;
            end
            st_nxt.irq = 1'b1;
            if (st_r.mode.pulse_en) begin
               st_nxt.out_lvl = ~st_r.out_lvl;
            end
         end else if (up_c) begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
         end else begin
            st_nxt.cnt = st_r.cnt - 16'h0001;
         end
      end
      // Register writes
      if (wr_timer_c) begin
         st_nxt.reload = PWDATA_I[timer_pkg::CNT_W-1:0];
         if (!st_r.ctrl.start) begin
            st_nxt.cnt = PWDATA_I[timer_pkg::CNT_W-1:0];
         end
      end
      if (wr_c && (PADDR_I == timer_pkg::ADDR_CTRL)) begin
         st_nxt.ctrl = timer_pkg::ctrl_reg_t'(PWDATA_I[1:0]);
      end
      if (wr_c && (PADDR_I == timer_pkg::ADDR_MODE)) begin
         st_nxt.mode = timer_pkg::mode_reg_t'(PWDATA_I[7:0]);
      end
      // Pin drive: released when used as direction input
      st_nxt.out_oe = st_r.mode.pulse_en &
         ~(is_event_c & st_r.mode.opt_b);
      // Bus answer, presented during the access phase
      st_nxt.pready = setup_c;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = timer_pkg::DATA_ZERO;
      if (setup_c) begin
         unique case (PADDR_I)
            timer_pkg::ADDR_CTRL: begin
               st_nxt.prdata[1:0] = st_r.ctrl;
            end
            timer_pkg::ADDR_MODE: begin
               st_nxt.prdata[7:0] = st_r.mode;
            end
            timer_pkg::ADDR_TIMER: begin
               st_nxt.prdata[15:0] = st_r.cnt;
            end
            timer_pkg::ADDR_STATUS: begin
               st_nxt.prdata[2:0] = {links.lvl[timer_pkg::PIN_DIR],
                                     st_r.out_oe, st_r.out_lvl};
            end
            default: begin
               st_nxt.pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= CORE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign PRDATA_O = st_r.prdata;
   assign PREADY_O = st_r.pready;
   assign PSLVERR_O = st_r.pslverr;
   assign TOGGLE_DIRECTION_PIN_O = st_r.out_lvl;
   assign TOGGLE_DIRECTION_PIN_OE_O = st_r.out_oe;
   assign IRQ_O = st_r.irq;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!rst_n);

   a_down_step: assert property (step_c && !wrap_c && !up_c && !wr_c
      |=> st_r.cnt == $past(st_r.cnt) - 16'h0001)
      else $error("counter did not decrement");
   a_timer_reload: assert property (is_timer_c && step_c &&
      st_r.cnt == 16'h0000 && !wr_c |=> st_r.cnt == $past(st_r.reload)
      && IRQ_O)
      else $error("underflow did not reload");
   a_stop_hold: assert property (!st_r.ctrl.start && !wr_c
      |=> $stable(st_r.cnt))
      else $error("counter moved while stopped");
   a_gate_hold: assert property (is_timer_c && st_r.mode.opt_a &&
      links.lvl[timer_pkg::PIN_GATE] != st_r.mode.opt_b && !wr_c
      |=> $stable(st_r.cnt))
      else $error("counter moved with gate closed");
   a_irq_cause: assert property (IRQ_O |-> $past(wrap_c))
      else $error("interrupt without wrap");
   a_write_stop: assert property (wr_timer_c && !st_r.ctrl.start
      |=> st_r.cnt == $past(PWDATA_I[15:0])
      && st_r.reload == st_r.cnt)
      else $error("stopped write did not load both");
   a_write_run: assert property (wr_timer_c && st_r.ctrl.start && !step_c
      |=> $stable(st_r.cnt) && st_r.reload == $past(PWDATA_I[15:0]))
      else $error("running write touched counter");
   a_pulse_toggle: assert property (wrap_c && st_r.mode.pulse_en
      |=> TOGGLE_DIRECTION_PIN_O != $past(TOGGLE_DIRECTION_PIN_O))
      else $error("output did not toggle");
   a_free_wrap: assert property (is_event_c && st_r.mode.free_run && up_c
      && wrap_c && !wr_c |=> st_r.cnt == 16'h0000)
      else $error("free run reloaded");
   a_up_reload: assert property (is_event_c && !st_r.mode.free_run &&
      up_c && wrap_c && !wr_c |=> st_r.cnt == $past(st_r.reload))
      else $error("overflow did not reload");
   a_bus_answer: assert property (setup_c |=> PREADY_O ##1 !PREADY_O)
      else $error("bus answer not one cycle");

   c_timer_under: cover property (is_timer_c && wrap_c);
   c_event_up: cover property (is_event_c && up_c && wrap_c);
   c_event_free: cover property (is_event_c && st_r.mode.free_run && wrap_c);
   c_run_write: cover property (wr_timer_c && st_r.ctrl.start);
endmodule : gp_timer

// ==== verification/far_side.sv ====
// Far-side model: subclock, other-timer overflows and direction pin
`timescale 1ns/1ps
module far_side (
   input wire logic clk_i,
   input wire logic fire_i,
   input wire logic [1:0] sel_i,
   input wire logic dir_lvl_i,
   input wire logic pin_o_i,
   input wire logic pin_oe_i,
   output logic sub_o,
   output logic b1_o,
   output logic x0_o,
   output logic x2_o,
   output wire logic dir_o
);
   // ==========================================================
   // Subclock runs free at four system cycles, phase unrelated
   initial begin
      b1_o = 1'h0;
      x0_o = 1'h0;
      x2_o = 1'h0;
      sub_o = 1'h0;
      #37;
      forever #200 sub_o = ~sub_o;
   end
   // ==========================================================
   // One-cycle overflow pulse on the chosen line
   always @(posedge clk_i) begin
      b1_o <= fire_i && (sel_i == 2'h1);
      x0_o <= fire_i && (sel_i == 2'h2);
      x2_o <= fire_i && (sel_i == 2'h3);
   end
   // Pin level: the channel's drive wins while it is enabled
   assign dir_o = pin_oe_i ? pin_o_i : dir_lvl_i;
endmodule : far_side

// ==== verification/gp_timer_tb.sv ====
// Self-checking bench for the reloadable timer channel
`timescale 1ns/1ps
module gp_timer_tb;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic psel = 1'h0;
   logic pen = 1'h0;
   logic pwr = 1'h0;
   logic [7:0] padr = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic ev = 1'h0;
   logic dir_lvl = 1'h0;
   logic fire = 1'h0;
   logic [1:0] sel = 2'h0;
   logic [31:0] prd, r, r2;
   logic prdy, perr, e, up, pin_o, oe, dir_w, sub, b1, x0, x2, irq;
   int failures = 0;
   int n_checks = 0;
   int irqs = 0;
   int cyc = 0;
   int last = 0;
   int gap = 0;
   int seed = 32'h6523;
   int n, k;
   always #50 clk = ~clk;
   always @(negedge clk) begin
      cyc++;
      if (irq === 1'h1) begin
         irqs++;
         gap = cyc - last;
         last = cyc;
      end
   end
   gp_timer dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
      .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
      .EVENT_GATE_INPUT_PIN_I(ev), .TOGGLE_DIRECTION_PIN_I(dir_w),
      .TOGGLE_DIRECTION_PIN_O(pin_o), .TOGGLE_DIRECTION_PIN_OE_O(oe),
      .SUBCLOCK_I(sub), .B_TIMER_ONE_OVF_I(b1), .X_TIMER_ZERO_OVF_I(x0),
      .X_TIMER_TWO_OVF_I(x2), .IRQ_O(irq));
   far_side far (.clk_i(clk), .fire_i(fire), .sel_i(sel),
      .dir_lvl_i(dir_lvl), .pin_o_i(pin_o), .pin_oe_i(oe), .sub_o(sub),
      .b1_o(b1), .x0_o(x0), .x2_o(x2), .dir_o(dir_w));
   // ==========================================================
   // Expectations
   function automatic logic [31:0] md(input logic [1:0] m, input logic a,
      input logic b, input logic fr, input logic [1:0] s);
      return {24'h0, s, fr, b, a, 1'h1, m};
   endfunction : md
   function automatic int dv(input int s);
      return (s == 0) ? 1 : (s == 1) ? 8 : (s == 2) ? 32 : 128;
   endfunction : dv
   function automatic logic [31:0] cnt(input logic [15:0] b, input int c,
      input logic u);
      return {16'h0, u ? b + 16'(c) : b - 16'(c)};
   endfunction : cnt
   // ==========================================================
   // Bus and compare tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'h1;
      pen <= 1'h0;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'h1;
      i = 0;
      // Answer is looked at mid-cycle, where it is settled
      do begin
         @(negedge clk);
         i++;
      end while (prdy !== 1'h1 && i < 20);
      chk(i < 20, 1);
      r = prd;
      e = perr;
      // Request stands until the rising edge that samples pready
      @(posedge clk);
      psel <= 1'h0;
      pen <= 1'h0;
   endtask : apb
   task wait_irqs(input int c);
      int s;
      int i;
      s = irqs;
      for (i = 0; i < 20000 && irqs < s + c; i++) @(negedge clk);
      chk(irqs >= s + c, 1);
   endtask : wait_irqs
   task halt;
      apb(1'h1, timer_pkg::ADDR_CTRL, 32'h0);
      repeat (6) @(posedge clk);
      chk(pin_o, irqs[0]);
   endtask : halt
   task pulses(input int c, input logic use_pin);
      repeat (c) begin
         @(posedge clk);
         ev <= use_pin;
         fire <= !use_pin;
         @(posedge clk);
         fire <= 1'h0;
         repeat (3) @(posedge clk);
         ev <= 1'h0;
         repeat (3) @(posedge clk);
      end
      repeat (6) @(posedge clk);
   endtask : pulses
   task end_sim;
      if (failures == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      end_sim;
   end
   // ==========================================================
   // Scenarios
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'h1;
      repeat (3) @(posedge clk);
      chk({irq, pin_o}, 0);
      for (k = 0; k < 5; k++) begin
         apb(1'h0, 8'(k * 4), 32'h0);
         chk({e, r}, {k == 4, 32'h0});
      end
      for (k = 0; k < 4; k++) begin
         n = $random(seed) & 3;
         apb(1'h1, timer_pkg::ADDR_MODE, md(2'h0, 0, 0, 0, 2'(k)));
         apb(1'h1, timer_pkg::ADDR_TIMER, n);
         apb(1'h0, timer_pkg::ADDR_TIMER, 32'h0);
         chk(r, n);
         apb(1'h1, timer_pkg::ADDR_CTRL, 32'h1);
         wait_irqs(3);
         chk(gap, (n + 1) * dv(k));
         halt;
      end
      apb(1'h1, timer_pkg::ADDR_MODE, md(2'h0, 0, 0, 0, 2'h0));
      apb(1'h1, timer_pkg::ADDR_TIMER, 32'h30);
      apb(1'h1, timer_pkg::ADDR_CTRL, 32'h1);
      apb(1'h1, timer_pkg::ADDR_TIMER, 32'h6);
      apb(1'h0, timer_pkg::ADDR_TIMER, 32'h0);
      chk(r, 32'h2C);
      wait_irqs(3);
      chk(gap, 7);
      halt;
      apb(1'h1, timer_pkg::ADDR_MODE, md(2'h0, 1, 1, 0, 2'h0));
      apb(1'h1, timer_pkg::ADDR_TIMER, 32'h1000);
      apb(1'h1, timer_pkg::ADDR_CTRL, 32'h1);
      apb(1'h0, timer_pkg::ADDR_TIMER, 32'h0);
      r2 = r;
      apb(1'h0, timer_pkg::ADDR_TIMER, 32'h0);
      chk(r, r2);
      ev <= 1'h1;
      repeat (5) @(posedge clk);
      apb(1'h0, timer_pkg::ADDR_TIMER, 32'h0);
      r2 = r;
      apb(1'h0, timer_pkg::ADDR_TIMER, 32'h0);
      chk(r2 - r, 3);
      halt;
      apb(1'h0, timer_pkg::ADDR_TIMER, 32'h0);
      chk(r, r2 - 32'h3 - 32'h5);
      ev <= 1'h0;
      for (k = 0; k < 2; k++) begin
         n = 1 + ($random(seed) & 3);
         up = $random(seed) & 1;
         apb(1'h1, timer_pkg::ADDR_MODE, md(2'h1, k[0], 0, 0, 2'h0));
         apb(1'h1, timer_pkg::ADDR_TIMER, 32'h0100);
         apb(1'h1, timer_pkg::ADDR_CTRL, {30'h0, up, 1'h1});
         pulses(n, 1'h1);
         ev <= 1'h1;
         repeat (6) @(posedge clk);
         apb(1'h0, timer_pkg::ADDR_TIMER, 32'h0);
         chk(r, cnt(16'h0100, n + k, up));
         halt;
         ev <= 1'h0;
      end
      for (k = 1; k < 4; k++) begin
         n = 1 + ($random(seed) & 3);
         sel <= 2'(k);
         apb(1'h1, timer_pkg::ADDR_MODE, md(2'h1, 1, 0, 0, 2'(k)));
         apb(1'h1, timer_pkg::ADDR_TIMER, 32'h0050);
         apb(1'h1, timer_pkg::ADDR_CTRL, 32'h1);
         pulses(n, 1'h0);
         apb(1'h0, timer_pkg::ADDR_TIMER, 32'h0);
         chk(r, cnt(16'h0050, n, 1'h0));
         halt;
      end
      sel <= 2'h1;
      apb(1'h1, timer_pkg::ADDR_MODE, md(2'h1, 1, 1, 0, 2'h1));
      apb(1'h1, timer_pkg::ADDR_TIMER, 32'h0050);
      apb(1'h1, timer_pkg::ADDR_CTRL, 32'h1);
      chk(oe, 0);
      dir_lvl <= 1'h1;
      repeat (4) @(posedge clk);
      pulses(2, 1'h0);
      apb(1'h0, timer_pkg::ADDR_TIMER, 32'h0);
      chk(r, 32'h0052);
      dir_lvl <= 1'h0;
      repeat (4) @(posedge clk);
      pulses(3, 1'h0);
      apb(1'h0, timer_pkg::ADDR_TIMER, 32'h0);
      chk(r, 32'h004F);
      halt;
      for (k = 0; k < 3; k++) begin
         up = (k < 2);
         n = up ? 32'hFFFD : 32'h2;
         apb(1'h1, timer_pkg::ADDR_MODE, md(2'h1, 1, 0, k == 1, 2'h1));
         apb(1'h1, timer_pkg::ADDR_TIMER, n);
         apb(1'h1, timer_pkg::ADDR_CTRL, {30'h0, up, 1'h1});
         r2 = irqs;
         pulses(3, 1'h0);
         apb(1'h0, timer_pkg::ADDR_TIMER, 32'h0);
         chk(r, (k == 1) ? 32'h0 : n);
         chk(irqs - r2, 1);
         halt;
      end
      end_sim;
   end
endmodule : gp_timer_tb
